/* shared/cpp_pkg.sv */
// constants and types shared by the packet port and its register-side controller
`default_nettype none
package cpp_pkg;
  localparam int unsigned TX_AW        = 8;   // 64-bit words in transmit buffer
  localparam int unsigned RX_AW        = 9;   // 64-bit words in receive buffer
  localparam int unsigned LEN_W        = 16;
  localparam int unsigned BEAT_W       = 13;
  localparam int unsigned HDR_BYTES    = 38;
  localparam int unsigned HDR_CYCLES   = 5;
  localparam int unsigned HDR_CNT_W    = 3;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned FIFO_LVL_W   = 4;
  localparam int unsigned SW_AW        = 8;
  // controller register byte offsets
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_TX_LEN   = 8'h04;
  localparam logic [7:0]  REG_TX_DATA  = 8'h08;
  localparam logic [7:0]  REG_HDR_EN_L = 8'h10;
  localparam logic [7:0]  REG_HDR_EN_H = 8'h14;
  localparam logic [7:0]  REG_RX_LVL   = 8'h18;
  localparam logic [7:0]  REG_RX_POP   = 8'h1c;
  localparam logic [7:0]  REG_RX_PTR   = 8'h20;
  localparam logic [7:0]  REG_RX_DATA  = 8'h24;
  localparam logic [7:0]  REG_HDR_EXP  = 8'h40;  // ten words, 0x40..0x64
  localparam int unsigned HDR_EXP_WORDS = 10;
  localparam int unsigned CTRL_SEND_BIT = 0;
  localparam int unsigned CTRL_TXPTR_CLR_BIT = 1;
  localparam logic [LEN_W-1:0] TX_LEN_RST = 16'h0000;
  typedef enum logic [1:0] {
    CPP_TX_IDLE = 2'b00,
    CPP_TX_WAIT = 2'b01,
    CPP_TX_SEND = 2'b10
  } cpp_tx_state_t;
endpackage : cpp_pkg
`default_nettype wire

/* shared/cpp_ram_if.sv */
// 32-bit RAM-style link between the register-side controller and the packet port
`default_nettype none
interface cpp_ram_if;
  logic                                  tx_wr_en;
  logic [cpp_pkg::TX_AW:0]               tx_buf_write_ptr;
  logic [31:0]                           tx_wr_data;
  logic [cpp_pkg::LEN_W-1:0]             tx_pkt_length;
  logic                                  tx_send_request;
  logic                                  tx_in_progress;
  logic [cpp_pkg::HDR_BYTES*8-1:0]       hdr_expected_bytes;
  logic [cpp_pkg::HDR_BYTES-1:0]         hdr_byte_enables;
  logic [cpp_pkg::FIFO_LVL_W-1:0]        endptr_fifo_level;
  logic                                  endptr_fifo_pop;
  logic [cpp_pkg::RX_AW-1:0]             endptr_fifo_out;
  logic [cpp_pkg::RX_AW:0]               rx_buf_read_ptr;
  logic [31:0]                           rx_rd_data;
  modport dev (
    input  tx_wr_en, tx_buf_write_ptr, tx_wr_data, tx_pkt_length, tx_send_request,
    input  hdr_expected_bytes, hdr_byte_enables, endptr_fifo_pop, rx_buf_read_ptr,
    output tx_in_progress, endptr_fifo_level, endptr_fifo_out, rx_rd_data
  );
  modport ctl (
    output tx_wr_en, tx_buf_write_ptr, tx_wr_data, tx_pkt_length, tx_send_request,
    output hdr_expected_bytes, hdr_byte_enables, endptr_fifo_pop, rx_buf_read_ptr,
    input  tx_in_progress, endptr_fifo_level, endptr_fifo_out, rx_rd_data
  );
endinterface : cpp_ram_if
`default_nettype wire

/* rtl/cpp_packet_port.sv */
// packet port: transmit engine, receive engine with header filter, end-pointer fifo
`default_nettype none
// ----------------------------------------------------------------------------
// end-pointer fifo
// ----------------------------------------------------------------------------
module cpp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned LVL_W = 4
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out,
  output logic [LVL_W-1:0]      level_out
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [LVL_W-1:0] level_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (level_r != LVL_W'(DEPTH));
  assign out_valid_out = (level_r != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;
  assign out_data_out  = mem_r[rd_ptr_r];
  assign level_out     = level_r;

  always_ff @(posedge clock_in)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      level_r <= level_r + LVL_W'(push) - LVL_W'(pop);
    end
  end
endmodule : cpp_fifo

// ----------------------------------------------------------------------------
// packet port, all on the MAC-side clock
// ----------------------------------------------------------------------------
module cpp_packet_port (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  cpp_ram_if.dev           bus,
  output logic [63:0]      tx_stream_word_out,
  output logic             tx_stream_valid_out,
  input  wire logic        tx_stream_ready_in,
  output logic [7:0]       tx_byte_strobe_out,
  output logic             tx_stream_end_out,
  input  wire logic [63:0] rx_stream_word_in,
  input  wire logic        rx_stream_valid_in,
  input  wire logic        rx_stream_end_in,
  output logic             rx_stream_ready_out
);
  // --------------------------------------------------------------------------
  // transmit buffer and engine
  // --------------------------------------------------------------------------
  logic [31:0]                  tx_ram_lo [2**cpp_pkg::TX_AW];
  logic [31:0]                  tx_ram_hi [2**cpp_pkg::TX_AW];
  cpp_pkg::cpp_tx_state_t       tx_state_r;
  logic [cpp_pkg::TX_AW-1:0]    tx_buf_read_ptr_r;
  logic [cpp_pkg::BEAT_W-1:0]   tx_beats_left_r;
  logic [2:0]                   tx_final_bytes_r;
  logic [cpp_pkg::LEN_W-1:0]    tx_len_r;
  logic                         tx_in_progress_r;
  logic                         tx_valid_r;
  logic [63:0]                  tx_word_r;
  logic                         tx_accept;
  logic [cpp_pkg::LEN_W:0]      tx_len_plus;

  assign tx_accept   = tx_valid_r & tx_stream_ready_in;
  assign tx_len_plus = {1'b0, tx_len_r} + 17'h00007;

  always_ff @(posedge clock_in)
  begin
    if (bus.tx_wr_en)
    begin
      if (bus.tx_buf_write_ptr[0])
      begin
        tx_ram_hi[bus.tx_buf_write_ptr[cpp_pkg::TX_AW:1]] <= bus.tx_wr_data;
      end
      else
      begin
        tx_ram_lo[bus.tx_buf_write_ptr[cpp_pkg::TX_AW:1]] <= bus.tx_wr_data;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_state_r        <= cpp_pkg::CPP_TX_IDLE;
      tx_buf_read_ptr_r <= '0;
      tx_beats_left_r   <= '0;
      tx_final_bytes_r  <= '0;
      tx_len_r          <= cpp_pkg::TX_LEN_RST;
      tx_in_progress_r  <= 1'b0;
      tx_valid_r        <= 1'b0;
      tx_word_r         <= '0;
    end
    else
    begin
      case (tx_state_r)
        cpp_pkg::CPP_TX_IDLE:
        begin
          // zero length requests are dropped
          if (bus.tx_send_request && bus.tx_pkt_length != '0)
          begin
            tx_len_r   <= bus.tx_pkt_length;
            tx_state_r <= cpp_pkg::CPP_TX_WAIT;
          end
        end
        cpp_pkg::CPP_TX_WAIT:
        begin
          if (tx_stream_ready_in)
          begin
            tx_in_progress_r  <= 1'b1;
            tx_beats_left_r   <= tx_len_plus[cpp_pkg::BEAT_W+2:3];
            tx_final_bytes_r  <= tx_len_r[2:0];
            tx_word_r         <= {tx_ram_hi[0], tx_ram_lo[0]};
            tx_buf_read_ptr_r <= 8'h01;
            tx_valid_r        <= 1'b1;
            tx_state_r        <= cpp_pkg::CPP_TX_SEND;
          end
        end
        cpp_pkg::CPP_TX_SEND:
        begin
          if (tx_accept)
          begin
            if (tx_beats_left_r == 13'h0001)
            begin
              tx_valid_r       <= 1'b0;
              tx_in_progress_r <= 1'b0;
              tx_state_r       <= cpp_pkg::CPP_TX_IDLE;
            end
            else
            begin
              tx_word_r         <= {tx_ram_hi[tx_buf_read_ptr_r], tx_ram_lo[tx_buf_read_ptr_r]};
              tx_buf_read_ptr_r <= tx_buf_read_ptr_r + 1'b1;
              tx_beats_left_r   <= tx_beats_left_r - 1'b1;
            end
          end
        end
        default:
        begin
          tx_state_r <= cpp_pkg::CPP_TX_IDLE;
        end
      endcase
    end
  end

  assign tx_stream_word_out  = tx_word_r;
  assign tx_stream_valid_out = tx_valid_r;
  assign tx_stream_end_out   = tx_valid_r & (tx_beats_left_r == 13'h0001);
  assign tx_byte_strobe_out  = !tx_stream_end_out ? 8'hff :
                               8'hff >> (3'h0 - tx_final_bytes_r);
  assign bus.tx_in_progress  = tx_in_progress_r;

  // --------------------------------------------------------------------------
  // receive buffer, header filter and commit
  // --------------------------------------------------------------------------
  logic [63:0]                  rx_ram [2**cpp_pkg::RX_AW];
  logic                         rx_in_pkt_r;
  logic [cpp_pkg::RX_AW-1:0]    rx_buf_write_ptr_r;
  logic [cpp_pkg::RX_AW-1:0]    rx_committed_ptr_r;
  logic [cpp_pkg::HDR_CNT_W-1:0] hdr_cycle_r;
  logic [cpp_pkg::HDR_BYTES-1:0] hdr_match_flags_r;
  logic [cpp_pkg::HDR_BYTES-1:0] hdr_flags_nxt;
  logic [cpp_pkg::HDR_CNT_W-1:0] hdr_cycle_now;
  logic [cpp_pkg::RX_AW-1:0]    rx_wr_addr;
  logic [cpp_pkg::RX_AW-1:0]    rx_end_ptr;
  logic                         rx_commit_pulse;
  logic                         fifo_in_ready;

  assign rx_wr_addr    = rx_in_pkt_r ? rx_buf_write_ptr_r : rx_committed_ptr_r;
  assign rx_end_ptr    = rx_wr_addr + 1'b1;
  assign hdr_cycle_now = rx_in_pkt_r ? hdr_cycle_r : '0;

  // per-byte compare; unseen enabled bytes fail so short packets are rejected
  generate
    for (genvar b = 0; b < cpp_pkg::HDR_BYTES; b++)
    begin : g_hdr
      always_comb
      begin
        hdr_flags_nxt[b] = hdr_match_flags_r[b];
        if (!rx_in_pkt_r)
        begin
          hdr_flags_nxt[b] = ~bus.hdr_byte_enables[b];
        end
        if (hdr_cycle_now == 3'(b / 8) && hdr_cycle_now < 3'(cpp_pkg::HDR_CYCLES))
        begin
          hdr_flags_nxt[b] = ~bus.hdr_byte_enables[b] |
                             (rx_stream_word_in[(b%8)*8 +: 8] == bus.hdr_expected_bytes[b*8 +: 8]);
        end
      end
    end
  endgenerate

  // a full fifo drops the packet as if rejected
  assign rx_commit_pulse = rx_stream_valid_in & rx_stream_end_in & (&hdr_flags_nxt) & fifo_in_ready;

  always_ff @(posedge clock_in)
  begin
    if (rx_stream_valid_in)
    begin
      rx_ram[rx_wr_addr] <= rx_stream_word_in;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_in_pkt_r        <= 1'b0;
      rx_buf_write_ptr_r <= '0;
      rx_committed_ptr_r <= '0;
      hdr_cycle_r        <= '0;
      hdr_match_flags_r  <= '0;
    end
    else if (rx_stream_valid_in)
    begin
      rx_in_pkt_r        <= ~rx_stream_end_in;
      rx_buf_write_ptr_r <= rx_end_ptr;
      hdr_match_flags_r  <= hdr_flags_nxt;
      hdr_cycle_r        <= (hdr_cycle_now == 3'(cpp_pkg::HDR_CYCLES)) ? hdr_cycle_now : hdr_cycle_now + 1'b1;
      if (rx_commit_pulse)
      begin
        rx_committed_ptr_r <= rx_end_ptr;
      end
    end
  end

  cpp_fifo #(
    .WIDTH (cpp_pkg::RX_AW),
    .DEPTH (cpp_pkg::FIFO_DEPTH),
    .LVL_W (cpp_pkg::FIFO_LVL_W)
  ) u_rx_endptr_fifo (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (rx_commit_pulse),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (rx_end_ptr),
    .out_valid_out (),
    .out_ready_in  (bus.endptr_fifo_pop),
    .out_data_out  (bus.endptr_fifo_out),
    .level_out     (bus.endptr_fifo_level)
  );

  assign rx_stream_ready_out = fifo_in_ready;
  // 32-bit read side, low half at even addresses
  assign bus.rx_rd_data = bus.rx_buf_read_ptr[0] ? rx_ram[bus.rx_buf_read_ptr[cpp_pkg::RX_AW:1]][63:32]
                                                 : rx_ram[bus.rx_buf_read_ptr[cpp_pkg::RX_AW:1]][31:0];
endmodule : cpp_packet_port
`default_nettype wire

/* rtl/cpp_sw_ctrl.sv */
// register-side controller: software registers driving the packet port link
`default_nettype none
module cpp_sw_ctrl (
  input  wire logic                      clock_in,
  input  wire logic                      reset_n_in,
  input  wire logic [cpp_pkg::SW_AW-1:0] addr_in,
  input  wire logic [31:0]               wr_data_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic [31:0]                    rd_data_out,
  cpp_ram_if.ctl                         bus
);
  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [cpp_pkg::TX_AW:0]          tx_ptr_r;
  logic [cpp_pkg::LEN_W-1:0]        tx_len_r;
  logic                             send_r;
  logic [cpp_pkg::HDR_BYTES-1:0]    hdr_en_r;
  logic [31:0]                      hdr_exp_r [cpp_pkg::HDR_EXP_WORDS];
  logic [cpp_pkg::RX_AW:0]          rx_ptr_r;
  logic [31:0]                      rd_data_r;
  logic [31:0]                      rd_nxt;
  logic                             is_pop;
  logic                             is_rx_data;

  assign is_pop     = rd_in & (addr_in == cpp_pkg::REG_RX_POP);
  assign is_rx_data = rd_in & (addr_in == cpp_pkg::REG_RX_DATA);

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_ptr_r <= '0;
      tx_len_r <= cpp_pkg::TX_LEN_RST;
      send_r   <= 1'b0;
      hdr_en_r <= '0;
      rx_ptr_r <= '0;
      for (int i = 0; i < cpp_pkg::HDR_EXP_WORDS; i++)
      begin
        hdr_exp_r[i] <= '0;
      end
    end
    else
    begin
      send_r <= wr_in & (addr_in == cpp_pkg::REG_CTRL) & wr_data_in[cpp_pkg::CTRL_SEND_BIT];
      if (wr_in)
      begin
        case (addr_in)
          cpp_pkg::REG_CTRL:
          begin
            if (wr_data_in[cpp_pkg::CTRL_TXPTR_CLR_BIT])
            begin
              tx_ptr_r <= '0;
            end
          end
          cpp_pkg::REG_TX_LEN:   tx_len_r <= wr_data_in[cpp_pkg::LEN_W-1:0];
          cpp_pkg::REG_TX_DATA:  tx_ptr_r <= tx_ptr_r + 1'b1;
          cpp_pkg::REG_HDR_EN_L: hdr_en_r[31:0] <= wr_data_in;
          cpp_pkg::REG_HDR_EN_H: hdr_en_r[cpp_pkg::HDR_BYTES-1:32] <= wr_data_in[cpp_pkg::HDR_BYTES-33:0];
          cpp_pkg::REG_RX_PTR:   rx_ptr_r <= wr_data_in[cpp_pkg::RX_AW:0];
          default:
          begin
            if (addr_in >= cpp_pkg::REG_HDR_EXP && addr_in < 8'(cpp_pkg::REG_HDR_EXP + 4*cpp_pkg::HDR_EXP_WORDS))
            begin
              hdr_exp_r[4'(addr_in[5:2])] <= wr_data_in;
            end
          end
        endcase
      end
      else if (is_rx_data)
      begin
        rx_ptr_r <= rx_ptr_r + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read decode, data one cycle after the strobe
  // --------------------------------------------------------------------------
  always_comb
  begin
    rd_nxt = '0;
    case (addr_in)
      cpp_pkg::REG_CTRL:     rd_nxt = {31'h00000000, bus.tx_in_progress};
      cpp_pkg::REG_TX_LEN:   rd_nxt = {16'h0000, tx_len_r};
      cpp_pkg::REG_HDR_EN_L: rd_nxt = hdr_en_r[31:0];
      cpp_pkg::REG_HDR_EN_H: rd_nxt = {26'h0000000, hdr_en_r[cpp_pkg::HDR_BYTES-1:32]};
      cpp_pkg::REG_RX_LVL:   rd_nxt = {28'h0000000, bus.endptr_fifo_level};
      cpp_pkg::REG_RX_POP:   rd_nxt = {22'h000000, bus.endptr_fifo_out, 1'b0};
      cpp_pkg::REG_RX_PTR:   rd_nxt = {22'h000000, rx_ptr_r};
      cpp_pkg::REG_RX_DATA:  rd_nxt = bus.rx_rd_data;
      default:               rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rd_data_r <= '0;
    end
    else if (rd_in)
    begin
      rd_data_r <= rd_nxt;
    end
    else
    begin
      rd_data_r <= '0;
    end
  end

  assign rd_data_out          = rd_data_r;
  assign bus.tx_wr_en         = wr_in & (addr_in == cpp_pkg::REG_TX_DATA);
  assign bus.tx_buf_write_ptr = tx_ptr_r;
  assign bus.tx_wr_data       = wr_data_in;
  assign bus.tx_pkt_length    = tx_len_r;
  assign bus.tx_send_request  = send_r;
  assign bus.hdr_byte_enables = hdr_en_r;
  assign bus.endptr_fifo_pop  = is_pop & (bus.endptr_fifo_level != '0);
  assign bus.rx_buf_read_ptr  = rx_ptr_r;

  generate
    for (genvar w = 0; w < cpp_pkg::HDR_EXP_WORDS; w++)
    begin : g_exp
      if (w < cpp_pkg::HDR_EXP_WORDS - 1)
      begin : g_full
        assign bus.hdr_expected_bytes[w*32 +: 32] = hdr_exp_r[w];
      end
      else
      begin : g_tail
        assign bus.hdr_expected_bytes[cpp_pkg::HDR_BYTES*8-1:w*32] = hdr_exp_r[w][15:0];
      end
    end
  endgenerate
endmodule : cpp_sw_ctrl
`default_nettype wire

/* verification/cpp_link_monitor.sv */
// concurrent checks on the packet port link and stream ports
`default_nettype none
module cpp_link_monitor (
  input wire logic                            clock_in,
  input wire logic                            reset_n_in,
  input wire logic                            tx_busy_in,
  input wire logic [cpp_pkg::LEN_W-1:0]       tx_len_in,
  input wire logic [cpp_pkg::FIFO_LVL_W-1:0]  fifo_level_in,
  input wire logic                            fifo_pop_in,
  input wire logic [63:0]                     tx_word_in,
  input wire logic                            tx_valid_in,
  input wire logic                            tx_ready_in,
  input wire logic [7:0]                      tx_strobe_in,
  input wire logic                            tx_end_in,
  input wire logic                            rx_valid_in,
  input wire logic                            rx_end_in,
  input wire logic                            rx_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence final_beat_s;
    tx_valid_in && tx_ready_in && tx_end_in;
  endsequence
  sequence idle_s;
    !tx_valid_in && !tx_busy_in;
  endsequence
  tx_hold_a: assert property (tx_valid_in && !tx_ready_in |=> tx_valid_in &&
    $stable(tx_word_in) && $stable(tx_end_in)) else $error("tx word changed before ready");
  first_word_a: assert property ($rose(tx_valid_in) |-> $past(tx_ready_in))
    else $error("tx word before ready");
  busy_valid_a: assert property (tx_valid_in |-> tx_busy_in)
    else $error("tx word without busy");
  full_strobe_a: assert property (tx_valid_in && !tx_end_in |-> tx_strobe_in == 8'hff)
    else $error("partial strobe before final word");
  final_strobe_a: assert property (tx_valid_in && tx_end_in |->
    tx_strobe_in == (8'hff >> ((4'd8 - {1'b0, tx_len_in[2:0]}) & 4'h7))) else $error("bad final strobe");
  tx_done_a: assert property (final_beat_s |=> idle_s)
    else $error("tx not idle after final word");
  level_bound_a: assert property (fifo_level_in <= 4'd8)
    else $error("fifo level above depth");
  level_rise_a: assert property (fifo_level_in > $past(fifo_level_in) |->
    $past(rx_valid_in && rx_end_in)) else $error("level rose without packet end");
  full_refuse_a: assert property (fifo_level_in == 4'd8 && !$past(fifo_pop_in) |-> !rx_ready_in)
    else $error("ready while fifo full");
endmodule : cpp_link_monitor
`default_nettype wire

/* verification/cpp_packet_port_tb.sv */
// self-checking bench for the packet port and its controller
`default_nettype none
module cpp_packet_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in, reset_n_in, wr_in, rd_in, rdy, rxv, rxe, txv, txe, rxr;
  logic [7:0]  addr_in, txk;
  logic [31:0] wr_data_in, rd_data_out;
  logic [63:0] txw, rxw;
  logic [7:0]  hdr [0:39];
  int          errors = 0, n_compared = 0, cptr = 0, q[$];
  cpp_ram_if u_if ();
  cpp_packet_port u_cpp_packet_port (.clock_in(clock_in), .reset_n_in(reset_n_in), .bus(u_if),
    .tx_stream_word_out(txw), .tx_stream_valid_out(txv), .tx_stream_ready_in(rdy), .tx_byte_strobe_out(txk),
    .tx_stream_end_out(txe), .rx_stream_word_in(rxw), .rx_stream_valid_in(rxv), .rx_stream_end_in(rxe),
    .rx_stream_ready_out(rxr));
  cpp_sw_ctrl u_cpp_sw_ctrl (.clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .bus(u_if));
  cpp_link_monitor u_mon (.clock_in(clock_in), .reset_n_in(reset_n_in), .tx_busy_in(u_if.tx_in_progress),
    .tx_len_in(u_if.tx_pkt_length), .fifo_level_in(u_if.endptr_fifo_level),
    .fifo_pop_in(u_if.endptr_fifo_pop), .tx_word_in(txw), .tx_valid_in(txv),
    .tx_ready_in(rdy), .tx_strobe_in(txk), .tx_end_in(txe), .rx_valid_in(rxv),
    .rx_end_in(rxe), .rx_ready_in(rxr));
  // ----------------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(posedge clock_in);
    chk(rd_data_out, exp);
  endtask : rd
  function automatic logic [31:0] dat(input int k);
    return 32'ha5a5_0000 | 32'(k);
  endfunction : dat
  // one send with the stream side stalling every other cycle
  task automatic send(input int len);
    int n, t, nb;
    n = 0;
    t = 0;
    nb = (len + 7) / 8;
    rdy <= 1'b0;
    wr(cpp_pkg::REG_TX_LEN, 32'(len));
    wr(cpp_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge clock_in);
    chk(txv, 0);
    chk(u_if.tx_in_progress, 0);
    while (n < nb && t < 200)
    begin
      @(posedge clock_in);
      t++;
      if (txv === 1'b1 && rdy === 1'b1)
      begin
        chk(txw, {dat(2 * n + 1), dat(2 * n)});
        chk(txk, (n == nb - 1) ? 8'hff >> ((8 - len % 8) % 8) : 8'hff);
        chk(txe, n == nb - 1);
        n++;
      end
      rdy <= ~rdy;
    end
    chk(n, nb);
    @(posedge clock_in);
    chk({txv, u_if.tx_in_progress}, 0);
  endtask : send
  // streams nw words; header byte at index bad is corrupted
  task automatic rx_pkt(input int nw, input int bad);
    logic [63:0] w;
    for (int k = 0; k < nw; k++)
    begin
      for (int b = 0; b < 8; b++)
        w[8*b +: 8] = (k < 5) ? hdr[8*k+b] ^ {7'h0, 8*k+b == bad} : 8'(k);
      @(posedge clock_in);
      rxv <= 1'b1;
      rxw <= w;
      rxe <= (k == nw - 1);
    end
    @(posedge clock_in);
    rxv <= 1'b0;
    rxe <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask : rx_pkt
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  initial
  begin
    repeat (20000) @(posedge clock_in);
    errors++;
    report_and_stop();
  end
  initial
  begin
    {reset_n_in, wr_in, rd_in, rdy, rxv, rxe, addr_in, wr_data_in, rxw} = '0;
    foreach (hdr[i]) hdr[i] = 8'h00;
    hdr[12] = 8'h08;
    hdr[14] = 8'h45;
    hdr[23] = 8'h06;
    hdr[37] = 8'h15;
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd(8'hfc, 32'h0);
    wr(cpp_pkg::REG_CTRL, 32'h2);
    for (int k = 0; k < 6; k++) wr(cpp_pkg::REG_TX_DATA, dat(k));
    for (int len = 1; len <= 24; len++) send(len);
    // a second request while waiting for ready must not change the packet
    rdy <= 1'b0;
    wr(cpp_pkg::REG_TX_LEN, 32'd8);
    wr(cpp_pkg::REG_CTRL, 32'h1);
    wr(cpp_pkg::REG_TX_LEN, 32'd16);
    wr(cpp_pkg::REG_CTRL, 32'h1);
    rdy <= 1'b1;
    @(posedge clock_in);
    rdy <= 1'b0;
    rd(cpp_pkg::REG_CTRL, 32'h1);
    chk(txw, {dat(1), dat(0)});
    chk(txe, 1);
    rdy <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk({txv, u_if.tx_in_progress}, 0);
    wr(cpp_pkg::REG_HDR_EN_L, 32'h0080_7000);
    wr(cpp_pkg::REG_HDR_EN_H, 32'h0000_0030);
    wr(8'h4c, 32'h0045_0008);
    wr(8'h54, 32'h0600_0000);
    wr(8'h64, 32'h0000_1500);
    rx_pkt(6, 99);
    q.push_back(6);
    foreach (hdr[i]) if (i < 38 && hdr[i] != 0 || i == 13 || i == 36) rx_pkt(7, i);
    rd(cpp_pkg::REG_RX_LVL, 32'h1);
    rx_pkt(7, 20);
    q.push_back(13);
    cptr = 13;
    rd(cpp_pkg::REG_RX_LVL, 32'h2);
    while (q.size() > 0) rd(cpp_pkg::REG_RX_POP, 32'(q.pop_front() * 2));
    wr(cpp_pkg::REG_RX_PTR, 32'd17);
    rd(cpp_pkg::REG_RX_DATA, 32'h0600_0001);
    for (int i = 0; i < 8; i++)
    begin
      rx_pkt(5, 99);
      cptr += 5;
      q.push_back(cptr);
    end
    chk(rxr, 0);
    rx_pkt(5, 99);
    rd(cpp_pkg::REG_RX_LVL, 32'h8);
    while (q.size() > 0) rd(cpp_pkg::REG_RX_POP, 32'(q.pop_front() * 2));
    rd(cpp_pkg::REG_RX_LVL, 32'h0);
    chk(rxr, 1);
    report_and_stop();
  end
endmodule : cpp_packet_port_tb
`default_nettype wire
